// *** recorder_pkg.sv ***
`default_nettype none
package recorder_pkg;
  // Clock and time base
  localparam int CLK_PERIOD_NS  = 8;
  localparam int MS_NS          = 1_000_000;
  localparam int MS_CYCLES      = MS_NS / CLK_PERIOD_NS;
  localparam int RATE_LOW_50_HZ = 1000;
  localparam int RATE_LOW_60_HZ = 1200;
  localparam int RATE_MULT_HIGH = 2;
  localparam int CLK_HZ         = 1_000_000_000 / CLK_PERIOD_NS;
  localparam int SMP_50_CYCLES  = CLK_HZ / RATE_LOW_50_HZ;
  localparam int SMP_60_CYCLES  = CLK_HZ / RATE_LOW_60_HZ;
  localparam int DIV_W          = 17;

  // Channel counts
  localparam int N_BIN = 64;
  localparam int N_ANA = 32;
  localparam int ANA_W = 16;

  // Register map, word index
  localparam logic [3:0] REG_CTRL      = 4'h0;
  localparam logic [3:0] REG_PRE       = 4'h1;
  localparam logic [3:0] REG_POST      = 4'h2;
  localparam logic [3:0] REG_MAX       = 4'h3;
  localparam logic [3:0] REG_STATUS    = 4'h4;
  localparam logic [3:0] REG_IRQ_STAT  = 4'h5;
  localparam logic [3:0] REG_IRQ_MASK  = 4'h6;
  localparam logic [3:0] REG_TIME      = 4'h7;
  localparam logic [3:0] REG_EVT_STAMP = 4'h8;
  localparam logic [3:0] REG_EVT_INFO  = 4'h9;

  // Control field positions
  localparam int CTRL_OPER = 0;
  localparam int CTRL_RATE = 1;
  localparam int CTRL_M60  = 2;

  // Time settings in ms
  localparam int         TW       = 14;
  localparam logic [TW-1:0] WIN_MIN  = 14'd100;
  localparam logic [TW-1:0] WIN_MAX  = 14'd1000;
  localparam logic [TW-1:0] WIN_DEF  = 14'd200;
  localparam logic [TW-1:0] LIM_MIN  = 14'd500;
  localparam logic [TW-1:0] LIM_MAX  = 14'd10000;
  localparam logic [TW-1:0] LIM_DEF  = 14'd1000;

  // Interrupt bits
  localparam int IRQ_W      = 4;
  localparam int IRQ_START  = 0;
  localparam int IRQ_DONE   = 1;
  localparam int IRQ_WARN   = 2;
  localparam int IRQ_LOST   = 3;

  // Event sources and codes
  localparam logic [3:0] SRC_RECORDER = 4'h0;
  localparam logic [3:0] EVC_START    = 4'h1;
  localparam logic [3:0] EVC_DONE     = 4'h2;
  localparam logic [3:0] EVC_WARN     = 4'h3;
  localparam int         EVT_DEPTH    = 16;

  typedef struct packed {
    logic [31:0] stamp;
    logic [3:0]  src;
    logic [3:0]  code;
  } evt_t;

  typedef struct packed {
    logic          oper;
    logic          rate;
    logic          m60;
    logic [TW-1:0] pre;
    logic [TW-1:0] post;
    logic [TW-1:0] lim;
  } settings_t;

  typedef enum logic [2:0] {
    ST_OFF     = 3'b000,
    ST_FILL    = 3'b001,
    ST_ARMED   = 3'b010,
    ST_CAPTURE = 3'b011,
    ST_POST    = 3'b100,
    ST_WARN    = 3'b101
  } rec_state_t;
endpackage : recorder_pkg
`default_nettype wire

// *** tick_divider.sv ***
`timescale 1ns/100ps
`default_nettype none
module tick_divider
  import recorder_pkg::*;
#(
  parameter int W = DIV_W
) (
  input  wire logic         clk_sys_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] period_i,
  output logic              tick_o
);
  logic [W-1:0] cnt_ff;
  wire          wrap = (cnt_ff >= period_i - W'(1));

  // One-cycle enable every period_i clocks
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      cnt_ff <= '0;
      tick_o <= 1'b0;
    end else begin
      cnt_ff <= wrap ? '0 : cnt_ff + W'(1);
      tick_o <= wrap;
    end
  end
endmodule : tick_divider
`default_nettype wire

// *** event_log.sv ***
`timescale 1ns/100ps
`default_nettype none
module event_log
  import recorder_pkg::*;
#(
  parameter int DEPTH = EVT_DEPTH,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic    clk_sys_i,
  input  wire logic    resetn_i,
  input  wire logic    push_i,
  input  wire evt_t    push_data_i,
  input  wire logic    pop_i,
  output evt_t         head_o,
  output logic [AW:0]  count_o,
  output logic         lost_o
);
  evt_t          mem [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0]   cnt_ff;
  wire           full  = (cnt_ff == (AW+1)'(DEPTH));
  wire           empty = (cnt_ff == '0);
  wire           do_wr = push_i && !full;
  wire           do_rd = pop_i && !empty;

  assign head_o  = empty ? '0 : mem[rd_ff];
  assign count_o = cnt_ff;
  assign lost_o  = push_i && full;

  always_ff @(posedge clk_sys_i) begin
    if (do_wr) begin
      mem[wr_ff] <= push_data_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff  <= wr_ff + AW'(do_wr);
      rd_ff  <= rd_ff + AW'(do_rd);
      cnt_ff <= cnt_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule : event_log
`default_nettype wire

// *** fault_recorder_ctl.sv ***
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module fault_recorder_ctl
  import recorder_pkg::*;
#(
  parameter bit          DUAL_RATE  = 1'b1,
  parameter int          MS_CNT     = MS_CYCLES,
  parameter int          SMP50_CNT  = SMP_50_CYCLES,
  parameter int          SMP60_CNT  = SMP_60_CYCLES,
  parameter int          NB         = N_BIN,
  parameter int          NA         = N_ANA
) (
  input  wire logic            clk_sys_i,
  input  wire logic            resetn_i,
  input  wire logic [3:0]      addr_i,
  input  wire logic [31:0]     wr_data_i,
  input  wire logic            wr_i,
  input  wire logic            rd_i,
  output logic [31:0]          rd_data_o,
  input  wire logic            capture_trigger_in_i,
  input  wire logic [NB-1:0]   bin_ch_i,
  input  wire logic [NA*ANA_W-1:0] ana_ch_i,
  input  wire logic            evt_i,
  input  wire logic [3:0]      evt_src_i,
  input  wire logic [3:0]      evt_code_i,
  output logic                 sample_valid_o,
  output logic [NB-1:0]        sample_bin_o,
  output logic [NA*ANA_W-1:0]  sample_ana_o,
  output logic                 recording_o,
  output logic                 capture_o,
  output logic                 warning_o,
  output logic                 irq_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Settings registers
  settings_t  set_ff;
  rec_state_t state_ff;
  rec_state_t nxt_state;
  logic [TW-1:0]    phase_ff;
  logic [TW-1:0]    nxt_phase;
  logic             released_ff;
  logic [31:0]      time_ff;
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] irq_mask_ff;
  logic             warn_seen_ff;

  function automatic logic [TW-1:0] clamp(input logic [31:0] v,
                                          input logic [TW-1:0] lo,
                                          input logic [TW-1:0] hi);
    if (v < 32'(lo)) begin
      return lo;
    end else if (v > 32'(hi)) begin
      return hi;
    end
    return v[TW-1:0];
  endfunction : clamp

  wire wr_ctrl = wr_i && (addr_i == REG_CTRL);
  wire wr_pre  = wr_i && (addr_i == REG_PRE);
  wire wr_post = wr_i && (addr_i == REG_POST);
  wire wr_max  = wr_i && (addr_i == REG_MAX);
  wire wr_mask = wr_i && (addr_i == REG_IRQ_MASK);
  wire rd_irq  = rd_i && (addr_i == REG_IRQ_STAT);
  wire rd_info = rd_i && (addr_i == REG_EVT_INFO);

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      // Operation off by default
      // Window defaults
      set_ff <= '{oper: 1'b0, rate: 1'b0, m60: 1'b0,
                  pre: WIN_DEF, post: WIN_DEF, lim: LIM_DEF};
    end else begin
      if (wr_ctrl) begin
        set_ff.oper <= wr_data_i[CTRL_OPER];
        // Rate bit only in dual variant
        set_ff.rate <= DUAL_RATE && wr_data_i[CTRL_RATE];
        set_ff.m60  <= wr_data_i[CTRL_M60];
      end
      if (wr_pre) begin
        set_ff.pre <= clamp(wr_data_i, WIN_MIN, WIN_MAX);
      end
      if (wr_post) begin
        set_ff.post <= clamp(wr_data_i, WIN_MIN, WIN_MAX);
      end
      if (wr_max) begin
        set_ff.lim <= clamp(wr_data_i, LIM_MIN, LIM_MAX);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time base and sample rate
  logic ms_tick;
  logic smp_tick;
  wire [DIV_W-1:0] smp_low = set_ff.m60 ? DIV_W'(SMP60_CNT)
                                        : DIV_W'(SMP50_CNT);
  wire [DIV_W-1:0] smp_per = set_ff.rate
                           ? DIV_W'(smp_low / DIV_W'(RATE_MULT_HIGH))
                           : smp_low;

  tick_divider #(.W(DIV_W)) u_ms_div (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .period_i  (DIV_W'(MS_CNT)),
    .tick_o    (ms_tick)
  );

  tick_divider #(.W(DIV_W)) u_smp_div (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .period_i  (smp_per),
    .tick_o    (smp_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Capture sequence
  // Window sum against limit
  wire [TW:0] win_sum  = {1'b0, set_ff.pre} + {1'b0, set_ff.post};
  wire        set_err  = win_sum > {1'b0, set_ff.lim};
  wire        trig     = capture_trigger_in_i;
  wire        start_ok = set_ff.oper && trig && released_ff;
  wire [TW-1:0] ph_inc = phase_ff + TW'(ms_tick);

  always_comb begin
    nxt_state = state_ff;
    nxt_phase = ph_inc;
    unique case (state_ff)
      ST_OFF: begin
        nxt_phase = '0;
        if (set_ff.oper) begin
          nxt_state = set_err ? ST_WARN : ST_FILL;
        end
      end
      ST_FILL: begin
        if (ph_inc >= set_ff.pre) begin
          nxt_state = ST_ARMED;
        end
      end
      ST_ARMED: begin
        nxt_phase = '0;
        if (start_ok) begin
          nxt_state = ST_CAPTURE;
        end
      end
      // End on trigger drop or limit
      ST_CAPTURE: begin
        if (!trig || ph_inc >= set_ff.lim) begin
          nxt_state = ST_POST;
          nxt_phase = '0;
        end
      end
      ST_POST: begin
        if (ph_inc >= set_ff.post) begin
          nxt_state = ST_FILL;
          nxt_phase = '0;
        end
      end
      ST_WARN: begin
        nxt_phase = '0;
        if (!set_err) begin
          nxt_state = ST_FILL;
        end
      end
      default: begin
        nxt_state = ST_OFF;
        nxt_phase = '0;
      end
    endcase
    if (!set_ff.oper) begin
      nxt_state = ST_OFF;
      nxt_phase = '0;
    end else if (set_err && state_ff != ST_WARN) begin
      nxt_state = ST_WARN;
      nxt_phase = '0;
    end
  end

  wire ev_start = (state_ff != ST_CAPTURE) && (nxt_state == ST_CAPTURE);
  wire ev_done  = (state_ff == ST_POST) && (nxt_state != ST_POST);
  wire ev_warn  = set_err && !warn_seen_ff;
  wire in_rec   = (nxt_state == ST_CAPTURE) || (nxt_state == ST_POST);
  wire sampling = (state_ff != ST_OFF) && (state_ff != ST_WARN);

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      state_ff     <= ST_OFF;
      phase_ff     <= '0;
      released_ff  <= 1'b1;
      warn_seen_ff <= 1'b0;
      time_ff      <= '0;
    end else begin
      state_ff     <= nxt_state;
      phase_ff     <= nxt_phase;
      released_ff  <= ev_start ? 1'b0 : (released_ff || !trig);
      warn_seen_ff <= set_err;
      time_ff      <= time_ff + 32'(ms_tick);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample path and status outputs
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      sample_valid_o <= 1'b0;
      sample_bin_o   <= '0;
      sample_ana_o   <= '0;
      recording_o    <= 1'b0;
      capture_o      <= 1'b0;
      warning_o      <= 1'b0;
    end else begin
      sample_valid_o <= smp_tick && sampling;
      if (smp_tick && sampling) begin
        sample_bin_o <= bin_ch_i;
        sample_ana_o <= ana_ch_i;
      end
      recording_o <= in_rec;
      capture_o   <= (nxt_state == ST_CAPTURE);
      warning_o   <= (nxt_state == ST_WARN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event log
  evt_t        head;
  logic [$clog2(EVT_DEPTH):0] evt_cnt;
  logic        log_lost;
  wire         int_ev   = ev_start || ev_done || ev_warn;
  wire [3:0]   int_code = ev_start ? EVC_START : (ev_done ? EVC_DONE
                                                          : EVC_WARN);
  wire evt_t   push_evt = int_ev
                        ? evt_t'{stamp: time_ff, src: SRC_RECORDER,
                                 code: int_code}
                        : evt_t'{stamp: time_ff, src: evt_src_i,
                                 code: evt_code_i};
  wire         ext_drop = evt_i && int_ev;

  event_log #(.DEPTH(EVT_DEPTH)) u_log (
    .clk_sys_i   (clk_sys_i),
    .resetn_i    (resetn_i),
    .push_i      (int_ev || evt_i),
    .push_data_i (push_evt),
    .pop_i       (rd_info),
    .head_o      (head),
    .count_o     (evt_cnt),
    .lost_o      (log_lost)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts and read port
  wire [IRQ_W-1:0] irq_set = {log_lost || ext_drop, ev_warn, ev_done,
                              ev_start};
  wire [IRQ_W-1:0] nxt_irq = (rd_irq ? '0 : irq_stat_ff) | irq_set;

  wire [31:0] rd_mux =
      (addr_i == REG_CTRL)      ? 32'({set_ff.m60, set_ff.rate,
                                       set_ff.oper}) :
      (addr_i == REG_PRE)       ? 32'(set_ff.pre) :
      (addr_i == REG_POST)      ? 32'(set_ff.post) :
      (addr_i == REG_MAX)       ? 32'(set_ff.lim) :
      (addr_i == REG_STATUS)    ? 32'({evt_cnt, set_err, released_ff,
                                       state_ff}) :
      (addr_i == REG_IRQ_STAT)  ? 32'(irq_stat_ff) :
      (addr_i == REG_IRQ_MASK)  ? 32'(irq_mask_ff) :
      (addr_i == REG_TIME)      ? time_ff :
      (addr_i == REG_EVT_STAMP) ? head.stamp :
      (addr_i == REG_EVT_INFO)  ? 32'({head.src, head.code}) :
                                  32'h0000_0000;

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
      irq_o       <= 1'b0;
      rd_data_o   <= '0;
    end else begin
      irq_stat_ff <= nxt_irq;
      if (wr_mask) begin
        irq_mask_ff <= wr_data_i[IRQ_W-1:0];
      end
      irq_o     <= |(nxt_irq & (wr_mask ? wr_data_i[IRQ_W-1:0]
                                        : irq_mask_ff));
      rd_data_o <= rd_i ? rd_mux : 32'h0000_0000;
    end
  end
endmodule : fault_recorder_ctl
`default_nettype wire

// *** recorder_ctl_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module recorder_ctl_assertions (
  input wire logic        clk_sys_i,
  input wire logic        resetn_i,
  input wire logic        rd_i,
  input wire logic [31:0] rd_data_o,
  input wire logic        capture_trigger_in_i,
  input wire logic        sample_valid_o,
  input wire logic        recording_o,
  input wire logic        capture_o,
  input wire logic        warning_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  ////////////////////////////////////////////////////////////////////////////
  // Trigger seen low since the last start
  logic low_seen_ff;
  logic nxt_low_seen;
  assign nxt_low_seen = !capture_trigger_in_i ? 1'b1
                      : (capture_o ? 1'b0 : low_seen_ff);
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      low_seen_ff <= 1'b1;
    end else begin
      low_seen_ff <= nxt_low_seen;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_cap_start;
    !capture_o ##1 capture_o;
  endsequence
  sequence s_cap_end;
    capture_o ##1 !capture_o;
  endsequence
  a_cap_needs_trig: assert property (s_cap_start |-> $past(capture_trigger_in_i))
    else $error("capture started without trigger");
  a_cap_not_warn: assert property (s_cap_start |-> !$past(warning_o))
    else $error("capture started in warning state");
  a_no_retrigger: assert property (s_cap_start |-> low_seen_ff)
    else $error("capture restarted by held trigger");
  a_cap_ends_drop: assert property (capture_o && !capture_trigger_in_i |=> !capture_o)
    else $error("capture kept after trigger drop");
  a_cap_in_rec: assert property (capture_o |-> recording_o)
    else $error("capture without recording");
  a_post_hold: assert property (s_cap_end |-> (recording_o || warning_o) [*8])
    else $error("post window cut short");
  a_warn_no_rec: assert property (warning_o |-> !recording_o)
    else $error("recording in warning state");
  a_warn_no_smp: assert property (warning_o |=> !sample_valid_o)
    else $error("sampling in warning state");
  a_smp_pulse: assert property (sample_valid_o |=> !sample_valid_o)
    else $error("sample strobe longer than one cycle");
  a_rd_data_idle: assert property (!rd_i |=> rd_data_o == 32'h0000_0000)
    else $error("read data outside read slot");
endmodule : recorder_ctl_assertions
bind fault_recorder_ctl recorder_ctl_assertions u_chk (
  .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .rd_i(rd_i),
  .rd_data_o(rd_data_o), .capture_trigger_in_i(capture_trigger_in_i),
  .sample_valid_o(sample_valid_o), .recording_o(recording_o),
  .capture_o(capture_o), .warning_o(warning_o)
);
`default_nettype wire

// *** trigger_source.sv ***
`timescale 1ns/100ps
`default_nettype none
module trigger_source (
  input  wire logic   clk_sys_i,
  input  wire logic   resetn_i,
  input  wire logic   trig_req_i,
  output logic        capture_trigger_in_o,
  output logic [63:0] bin_ch_o,
  output logic [511:0] ana_ch_o
);
  logic [15:0] cnt_ff;
  // single start level, dropped only on command
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      capture_trigger_in_o <= 1'b0;
      cnt_ff               <= 16'h0000;
    end else begin
      capture_trigger_in_o <= trig_req_i;
      cnt_ff               <= cnt_ff + 16'h0001;
    end
  end
  // full channel set, values change every cycle
  assign bin_ch_o = {4{cnt_ff}};
  assign ana_ch_o = {32{~cnt_ff}};
endmodule : trigger_source
`default_nettype wire

// *** fault_recorder_ctl_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module fault_recorder_ctl_tb;
  import recorder_pkg::*;
  localparam int MSC = 10;
  logic         clk_sys_i, resetn_i, wr, rd, trig_req, evt;
  logic         trig, smp, rec, cap, warn, irq;
  logic [3:0]   addr, esrc, ecode;
  logic [31:0]  wdat, rdat;
  logic [63:0]  bin;
  logic [511:0] ana;
  logic [63:0]  sbin;
  logic [511:0] sana;
  logic [31:0]  rdat_b, basic_rd;
  int           fails = 0;
  int           cmp_count = 0;
  trigger_source u_src (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .trig_req_i(trig_req), .capture_trigger_in_o(trig), .bin_ch_o(bin),
    .ana_ch_o(ana));
  fault_recorder_ctl #(.MS_CNT(MSC), .SMP50_CNT(8), .SMP60_CNT(6)) dut (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .addr_i(addr),
    .wr_data_i(wdat), .wr_i(wr), .rd_i(rd), .rd_data_o(rdat),
    .capture_trigger_in_i(trig), .bin_ch_i(bin), .ana_ch_i(ana),
    .evt_i(evt), .evt_src_i(esrc), .evt_code_i(ecode),
    .sample_valid_o(smp), .sample_bin_o(sbin), .sample_ana_o(sana),
    .recording_o(rec), .capture_o(cap), .warning_o(warn), .irq_o(irq));
  // Basic variant without the rate select
  fault_recorder_ctl #(.DUAL_RATE(1'b0), .MS_CNT(MSC), .SMP50_CNT(8),
    .SMP60_CNT(6)) dut_basic (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .addr_i(addr),
    .wr_data_i(wdat), .wr_i(wr), .rd_i(rd), .rd_data_o(rdat_b),
    .capture_trigger_in_i(trig), .bin_ch_i(bin), .ana_ch_i(ana),
    .evt_i(evt), .evt_src_i(esrc), .evt_code_i(ecode),
    .sample_valid_o(), .sample_bin_o(), .sample_ana_o(),
    .recording_o(), .capture_o(), .warning_o(), .irq_o());
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    wdat <= d;
    wr   <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    @(negedge clk_sys_i);
    d = rdat;
    basic_rd = rdat_b;
    @(posedge clk_sys_i);
  endtask : rd_reg
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e, input string nm);
    logic [31:0] d;
    rd_reg(a, d);
    chk(nm, e, d);
  endtask : rd_chk
  task automatic wait_st(input logic [2:0] st, input int lim);
    logic [31:0] d;
    for (int i = 0; i < lim; i++) begin
      rd_reg(REG_STATUS, d);
      if (d[2:0] === st) return;
    end
    fails++;
    $display("mismatch state expected %h seen %h", st, d[2:0]);
    results();
  endtask : wait_st
  task automatic wait_out(input int sel, input logic v, input int lim, output int n);
    logic s;
    for (n = 0; n < lim; n++) begin
      @(negedge clk_sys_i);
      s = (sel == 0) ? cap : (sel == 1) ? rec : smp;
      if (s === v) begin
        @(posedge clk_sys_i);
        return;
      end
    end
    fails++;
    $display("mismatch output %0d expected %b seen %b", sel, v, s);
    results();
  endtask : wait_out
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd_chk(REG_CTRL, 32'h0000_0000, "ctrl");
    rd_chk(REG_PRE, 32'h0000_00C8, "pre");
    rd_chk(REG_POST, 32'h0000_00C8, "post");
    rd_chk(REG_MAX, 32'h0000_03E8, "max");
    wr_reg(4'hF, 32'hFFFF_FFFF);
    rd_chk(4'hF, 32'h0000_0000, "unmapped");
    $display("test reset done");
  endtask : t_reset
  task automatic t_event();
    logic [31:0] t0, t1, d;
    rd_reg(REG_TIME, t0);
    evt   <= 1'b1;
    esrc  <= 4'h5;
    ecode <= 4'h7;
    @(posedge clk_sys_i);
    evt <= 1'b0;
    rd_reg(REG_TIME, t1);
    rd_reg(REG_STATUS, d);
    chk("event count", 32'h0000_0001, 32'(d[9:5]));
    rd_reg(REG_EVT_STAMP, d);
    chk("stamp", 32'h0000_0001, 32'(d >= t0 && d <= t1));
    rd_chk(REG_EVT_INFO, 32'h0000_0057, "event source");
    rd_reg(REG_TIME, t0);
    repeat (97) @(posedge clk_sys_i);
    rd_reg(REG_TIME, t1);
    chk("ms count", 32'h0000_000A, t1 - t0);
    $display("test event done");
  endtask : t_event
  task automatic t_clamp();
    logic [3:0]  ca [6];
    logic [31:0] cw [6];
    logic [31:0] ce [6];
    ca = '{REG_PRE, REG_PRE, REG_POST, REG_POST, REG_MAX, REG_MAX};
    cw = '{32'h0000_03E9, 32'h0000_0032, 32'h0000_03E9, 32'h0000_0063,
           32'h0000_2711, 32'h0000_01F3};
    ce = '{32'h0000_03E8, 32'h0000_0064, 32'h0000_03E8, 32'h0000_0064,
           32'h0000_2710, 32'h0000_01F4};
    for (int i = 0; i < 6; i++) begin
      wr_reg(ca[i], cw[i]);
      rd_chk(ca[i], ce[i], "clamped time");
    end
    $display("test clamp done");
  endtask : t_clamp
  task automatic t_off();
    trig_req <= 1'b1;
    repeat (20) @(posedge clk_sys_i);
    chk("capture off", 32'h0000_0000, 32'(cap | rec));
    trig_req <= 1'b0;
    $display("test off done");
  endtask : t_off
  task automatic t_warn();
    logic [31:0] d;
    rd_reg(REG_IRQ_STAT, d);
    wr_reg(REG_IRQ_MASK, 32'h0000_0000);
    wr_reg(REG_PRE, 32'h0000_012C);
    wr_reg(REG_POST, 32'h0000_00C9);
    wr_reg(REG_CTRL, 32'h0000_0001);
    repeat (4) @(posedge clk_sys_i);
    chk("warning", 32'h0000_0001, 32'(warn));
    chk("irq masked", 32'h0000_0000, 32'(irq));
    rd_reg(REG_STATUS, d);
    chk("status warn", 32'h0000_001D, 32'(d[4:0]));
    wr_reg(REG_IRQ_MASK, 32'h0000_0004);
    repeat (3) @(posedge clk_sys_i);
    chk("irq raised", 32'h0000_0001, 32'(irq));
    rd_reg(REG_IRQ_STAT, d);
    chk("warn status bit", 32'h0000_0004, d & 32'h0000_0004);
    repeat (3) @(posedge clk_sys_i);
    chk("irq cleared", 32'h0000_0000, 32'(irq));
    wr_reg(REG_POST, 32'h0000_00C8);
    repeat (4) @(posedge clk_sys_i);
    chk("equal sum", 32'h0000_0000, 32'(warn));
    wr_reg(REG_PRE, 32'h0000_0064);
    wr_reg(REG_POST, 32'h0000_0064);
    $display("test warn done");
  endtask : t_warn
  task automatic t_capture();
    logic [31:0] d;
    int          n;
    wr_reg(REG_IRQ_MASK, 32'h0000_0003);
    wait_st(3'h2, 800);
    rd_reg(REG_IRQ_STAT, d);
    trig_req <= 1'b1;
    wait_out(0, 1'b1, 4, n);
    chk("recording", 32'h0000_0001, 32'(rec));
    repeat (50) @(posedge clk_sys_i);
    chk("irq start", 32'h0000_0001, 32'(irq));
    trig_req <= 1'b0;
    wait_out(0, 1'b0, 4, n);
    chk("post recording", 32'h0000_0001, 32'(rec));
    wait_out(1, 1'b0, 1200, n);
    chk("post window", 32'h0000_0001, 32'(n >= 98*MSC && n <= 101*MSC));
    rd_reg(REG_IRQ_STAT, d);
    chk("start and done", 32'h0000_0003, d & 32'h0000_0003);
    $display("test capture done");
  endtask : t_capture
  task automatic t_held();
    int n;
    wait_st(3'h2, 800);
    trig_req <= 1'b1;
    wait_out(0, 1'b1, 4, n);
    wait_out(0, 1'b0, 6000, n);
    chk("limit", 32'h0000_0001, 32'(n >= 498*MSC && n <= 501*MSC));
    wait_st(3'h2, 1000);
    repeat (50) @(posedge clk_sys_i);
    chk("no retrigger", 32'h0000_0000, 32'(cap));
    trig_req <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    trig_req <= 1'b1;
    wait_out(0, 1'b1, 6, n);
    trig_req <= 1'b0;
    wait_out(1, 1'b0, 1200, n);
    $display("test held done");
  endtask : t_held
  task automatic t_rate();
    logic [31:0] cv [4];
    logic [31:0] pv [4];
    logic [31:0] d;
    logic [15:0] x;
    int          n;
    cv = '{32'h0000_0001, 32'h0000_0003, 32'h0000_0005, 32'h0000_0007};
    pv = '{32'h0000_0008, 32'h0000_0004, 32'h0000_0006, 32'h0000_0003};
    for (int i = 0; i < 4; i++) begin
      wr_reg(REG_CTRL, cv[i]);
      rd_reg(REG_CTRL, d);
      chk("rate bit", cv[i], d);
      chk("basic rate bit", cv[i] & 32'h0000_0005, basic_rd);
      repeat (3) wait_out(2, 1'b1, 20, n);
      chk("sample period", pv[i], 32'(n + 1));
      @(negedge clk_sys_i);
      x = bin[15:0] - 16'h0002;
      chk("sample bin", {2{x}}, sbin[63:32]);
      chk("sample ana", {2{~x}}, sana[511:480]);
    end
    $display("test rate done");
  endtask : t_rate
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn_i = 1'b0;
    wr       = 1'b0;
    rd       = 1'b0;
    trig_req = 1'b0;
    evt      = 1'b0;
    addr     = 4'h0;
    esrc     = 4'h0;
    ecode    = 4'h0;
    wdat     = 32'h0000_0000;
    repeat (12) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    t_reset();
    t_event();
    t_clamp();
    t_off();
    t_warn();
    t_capture();
    t_held();
    t_rate();
    results();
  end
endmodule : fault_recorder_ctl_tb
`default_nettype wire
